// ### core/dior_router.sv
// Purpose: Routes six discrete inputs and three outputs by per-channel function code
// Assumes: Inputs are asynchronous pins; status arrives on CLK
// Notes:   Selection value = polarity digit * 100 + function code
`timescale 1ns/1ps
`include "dior_cfg.svh"

// Contract
// - Every input and output channel has its own function-selection register.
// - Input codes 1 to 7 map to enable, alarm clear, gain, pulse clear, zero hold, reversal, pulse block.
// - Input codes 9, 10, 11 map to torque limit, speed limit and gear numerator select.
// - Input codes 14-17 form the speed and torque command selection bit pairs.
// - Input codes 18, 19, 20 switch position/speed, speed/torque and torque/position modes.
// - Input code 21 is an emergency halt, asserted when its contact opens.
// - Codes 22 and 23 are reverse and forward travel inhibit, asserted when the contact opens.
// - Codes 25 and 26 apply the reverse and forward torque caps.
// - An input with function code zero drives nothing.
// - Output codes 1 to 6 report ready, enabled, zero speed, speed reached, position, torque limit.
// - Output codes 7, 8, 9, 10 report fault, brake, overload caution and general warning.
// - An output with function code zero reports nothing.
// - Reset maps inputs 1-6 to enable, alarm clear, pulse clear, reverse, forward inhibit, halt.
// - An open normally-closed halt or limit input raises a sticky fault event.
module dior_router (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic [5:0]            DI,
  input  wire dior_pkg::dior_stat_t  STATUS,
  input  wire logic [3:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic [7:0]                 RDATA,
  output logic [2:0]                 DO,
  output dior_pkg::dior_func_t       FUNC,
  output logic                       IRQ
);
  import dior_pkg::*;

  logic [7:0]  sel_in  [`DIOR_NUM_IN];
  logic [7:0]  sel_out [`DIOR_NUM_OUT];
  logic [5:0]  di_s1;
  logic [5:0]  di_s2;
  logic [5:0]  act_in;
  logic [6:0]  code_in  [`DIOR_NUM_IN];
  logic [6:0]  code_out [`DIOR_NUM_OUT];
  logic [5:0]  low_in;
  logic [2:0]  low_out;
  logic [2:0]  next_do;
  logic [`DIOR_EV_W-1:0] irq_stat;
  logic [`DIOR_EV_W-1:0] irq_mask;
  logic [`DIOR_EV_W-1:0] ev;
  dior_func_t  next_func;
  logic [7:0]  next_rdata;
  logic        wr_stat;
  logic        wr_mask;

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  always_ff @(posedge CLK) begin
    if (RST) begin
      di_s1 <= 6'h00;
      di_s2 <= 6'h00;
    end else begin
      di_s1 <= DI;
      di_s2 <= di_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Selection registers and decode
  genvar g;
  generate
    for (g = 0; g < `DIOR_NUM_IN; g++) begin : g_in
      localparam logic [7:0] DEF = (g == 0) ? `DIOR_DEF_IN1 : (g == 1) ? `DIOR_DEF_IN2 :
                                   (g == 2) ? `DIOR_DEF_IN3 : (g == 3) ? `DIOR_DEF_IN4 :
                                   (g == 4) ? `DIOR_DEF_IN5 : `DIOR_DEF_IN6;
      wire hit = WR && (ADDR == `DIOR_A_IN_SEL0 + 4'(g));
      always_ff @(posedge CLK) begin
        if (RST)
          sel_in[g] <= DEF;
        else if (hit)
          sel_in[g] <= WDATA;
      end
      // Below 100 the hundreds digit is 0: active low
      assign low_in[g]  = sel_in[g] < `DIOR_HUNDRED;
      assign code_in[g] = low_in[g] ? sel_in[g][6:0]
                                    : 7'(sel_in[g] - `DIOR_HUNDRED);
      assign act_in[g]  = low_in[g] ? ~di_s2[g] : di_s2[g];
    end
    for (g = 0; g < `DIOR_NUM_OUT; g++) begin : g_out
      localparam logic [7:0] DEF = (g == 0) ? `DIOR_DEF_OUT1 :
                                   (g == 1) ? `DIOR_DEF_OUT2 : `DIOR_DEF_OUT3;
      wire hit = WR && (ADDR == `DIOR_A_OUT_SEL0 + 4'(g));
      always_ff @(posedge CLK) begin
        if (RST)
          sel_out[g] <= DEF;
        else if (hit)
          sel_out[g] <= WDATA;
      end
      assign low_out[g]  = sel_out[g] < `DIOR_HUNDRED;
      assign code_out[g] = low_out[g] ? sel_out[g][6:0]
                                      : 7'(sel_out[g] - `DIOR_HUNDRED);
    end
  endgenerate

  // OR of every channel carrying a given code; code zero matches nothing
  function automatic logic any_in(input logic [6:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < `DIOR_NUM_IN; i++)
      if (code != `DIOR_FI_NONE && code_in[i] == code)
        r = r | act_in[i];
    return r;
  endfunction

  // Contact-b: the function asserts when the assigned line is not energised
  function automatic logic nc_in(input logic [6:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < `DIOR_NUM_IN; i++)
      if (code_in[i] == code)
        r = r | ~act_in[i];
    return r;
  endfunction

  always_comb begin
    next_func = '0;
    next_func.servo_enable          = any_in(`DIOR_FI_SERVO_EN);
    next_func.alarm_clear           = any_in(`DIOR_FI_ALM_CLR);
    next_func.gain_switch           = any_in(`DIOR_FI_GAIN);
    next_func.pulse_count_clear     = any_in(`DIOR_FI_PCLR);
    next_func.zero_speed_hold       = any_in(`DIOR_FI_ZHOLD);
    next_func.command_reversal      = any_in(`DIOR_FI_CMDREV);
    next_func.pulse_block           = any_in(`DIOR_FI_PBLOCK);
    next_func.torque_limit_enable   = any_in(`DIOR_FI_TLIM);
    next_func.speed_limit_enable    = any_in(`DIOR_FI_SLIM);
    next_func.gear_numerator_select = any_in(`DIOR_FI_GEARN);
    next_func.speed_cmd_sel  = {any_in(`DIOR_FI_SPEED_CMD_SEL_BIT1), any_in(`DIOR_FI_SPEED_CMD_SEL_BIT0)};
    next_func.torque_cmd_sel = {any_in(`DIOR_FI_TRQ1), any_in(`DIOR_FI_TRQ0)};
    next_func.mode_pos_spd          = any_in(`DIOR_FI_PS);
    next_func.mode_spd_trq          = any_in(`DIOR_FI_ST);
    next_func.mode_trq_pos          = any_in(`DIOR_FI_TP);
    next_func.emergency_halt         = nc_in(`DIOR_FI_EHALT);
    next_func.reverse_travel_inhibit = nc_in(`DIOR_FI_RINH);
    next_func.forward_travel_inhibit = nc_in(`DIOR_FI_FINH);
    next_func.reverse_torque_cap    = any_in(`DIOR_FI_RTCAP);
    next_func.forward_torque_cap    = any_in(`DIOR_FI_FTCAP);
  end

  ////////////////////////////////////////////////////////////////////
  // Output selection
  always_comb begin
    for (int j = 0; j < `DIOR_NUM_OUT; j++) begin
      logic v;
      v = 1'b0;
      case (code_out[j])
        `DIOR_FO_READY:   v = STATUS.servo_ready;
        `DIOR_FO_ENABLED: v = STATUS.servo_enabled;
        `DIOR_FO_ZERO_SPEED_FLAG:    v = STATUS.zero_speed_flag;
        `DIOR_FO_SPDR:    v = STATUS.speed_reached;
        `DIOR_FO_POSC:    v = STATUS.position_complete;
        `DIOR_FO_TQL:     v = STATUS.torque_limit_reached;
        `DIOR_FO_FAULT:   v = STATUS.fault_output;
        `DIOR_FO_BRAKE:   v = STATUS.brake_control;
        `DIOR_FO_OVLD:    v = STATUS.overload_caution;
        `DIOR_FO_WARN:    v = STATUS.general_warning;
        default:          v = 1'b0;
      endcase
      // Unused channels stay deasserted regardless of polarity digit
      next_do[j] = (code_out[j] == 7'd0) ? 1'b0 : (low_out[j] ? ~v : v);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fault events and interrupt
  assign ev[`DIOR_EV_EHALT] = next_func.emergency_halt;
  assign ev[`DIOR_EV_RINH]  = next_func.reverse_travel_inhibit;
  assign ev[`DIOR_EV_FINH]  = next_func.forward_travel_inhibit;
  assign wr_stat = WR && (ADDR == `DIOR_A_IRQ_STAT);
  assign wr_mask = WR && (ADDR == `DIOR_A_IRQ_MASK);

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      // Set beats write-one-to-clear in the same cycle
      irq_stat <= (irq_stat & ~(wr_stat ? WDATA[`DIOR_EV_W-1:0] : '0)) | ev;
      if (wr_mask)
        irq_mask <= WDATA[`DIOR_EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    next_rdata = 8'h00;
    if (ADDR < `DIOR_A_OUT_SEL0)
      next_rdata = sel_in[ADDR[2:0]];
    else if (ADDR < `DIOR_A_STATUS)
      next_rdata = sel_out[2'(ADDR - `DIOR_A_OUT_SEL0)];
    else if (ADDR == `DIOR_A_STATUS)
      next_rdata = {5'h00, DO};
    else if (ADDR == `DIOR_A_IRQ_STAT)
      next_rdata = {5'h00, irq_stat};
    else if (ADDR == `DIOR_A_IRQ_MASK)
      next_rdata = {5'h00, irq_mask};
    else if (ADDR == `DIOR_A_PINS)
      next_rdata = {2'h0, di_s2};
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
      DO    <= 3'h0;
      FUNC  <= '0;
      IRQ   <= 1'b0;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
      DO    <= next_do;
      FUNC  <= next_func;
      IRQ   <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_zero_in_idle: assert property (@(posedge CLK) disable iff (RST)
    (code_in[0] == 7'd0 && code_in[1] != `DIOR_FI_SERVO_EN && code_in[2] != `DIOR_FI_SERVO_EN
     && code_in[3] != `DIOR_FI_SERVO_EN && code_in[4] != `DIOR_FI_SERVO_EN
     && code_in[5] != `DIOR_FI_SERVO_EN) |=> !FUNC.servo_enable)
    else $error("servo enable driven with no channel mapped");
  a_zero_out_idle: assert property (@(posedge CLK) disable iff (RST)
    code_out[0] == 7'd0 |=> !DO[0])
    else $error("disabled output channel asserted");
  a_out_ready: assert property (@(posedge CLK) disable iff (RST)
    (code_out[0] == `DIOR_FO_READY && !low_out[0]) |=> DO[0] == $past(STATUS.servo_ready))
    else $error("output ready mismatch");
  a_out_fault: assert property (@(posedge CLK) disable iff (RST)
    (code_out[1] == `DIOR_FO_FAULT && low_out[1]) |=> DO[1] == !$past(STATUS.fault_output))
    else $error("output fault mismatch");
  a_halt_open: assert property (@(posedge CLK) disable iff (RST)
    (code_in[5] == `DIOR_FI_EHALT && !act_in[5]) |=> FUNC.emergency_halt)
    else $error("halt not asserted on open contact");
  a_rinh_event: assert property (@(posedge CLK) disable iff (RST)
    FUNC.reverse_travel_inhibit |-> irq_stat[`DIOR_EV_RINH])
    else $error("reverse inhibit event not latched");
  a_irq_level: assert property (@(posedge CLK) disable iff (RST)
    (irq_stat & irq_mask) != '0 |=> IRQ)
    else $error("interrupt not raised");
  a_sel_write: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == `DIOR_A_IN_SEL0) |=> sel_in[0] == $past(WDATA))
    else $error("selection write lost");
  a_read_lat: assert property (@(posedge CLK) disable iff (RST)
    !RD |=> RDATA == 8'h00)
    else $error("read data outside read slot");
  // Single functions routed through channel 1, forward inhibit through channel 5, zero speed through output channel 3
  a_servo_map: assert property (@(posedge CLK) disable iff (RST)
    (code_in[0] == `DIOR_FI_SERVO_EN && act_in[0]) |=> FUNC.servo_enable)
    else $error("servo enable not routed");
  a_tlim_map: assert property (@(posedge CLK) disable iff (RST)
    (code_in[0] == `DIOR_FI_TLIM && act_in[0]) |=> FUNC.torque_limit_enable)
    else $error("torque limit enable not routed");
  a_gear_map: assert property (@(posedge CLK) disable iff (RST)
    (code_in[0] == `DIOR_FI_GEARN && act_in[0]) |=> FUNC.gear_numerator_select)
    else $error("gear numerator select not routed");
  a_speed_sel_map: assert property (@(posedge CLK) disable iff (RST)
    (code_in[0] == `DIOR_FI_SPEED_CMD_SEL_BIT1 && act_in[0]) |=> FUNC.speed_cmd_sel[1])
    else $error("speed command select bit not routed");
  a_torque_sel_map: assert property (@(posedge CLK) disable iff (RST)
    (code_in[0] == `DIOR_FI_TRQ0 && act_in[0]) |=> FUNC.torque_cmd_sel[0])
    else $error("torque command select bit not routed");
  a_mode_map: assert property (@(posedge CLK) disable iff (RST)
    (code_in[0] == `DIOR_FI_PS && act_in[0]) |=> FUNC.mode_pos_spd)
    else $error("mode switch not routed");
  a_finh_open: assert property (@(posedge CLK) disable iff (RST)
    (code_in[4] == `DIOR_FI_FINH && !act_in[4]) |=> FUNC.forward_travel_inhibit)
    else $error("forward inhibit not asserted on open contact");
  a_tcap_map: assert property (@(posedge CLK) disable iff (RST)
    (code_in[0] == `DIOR_FI_FTCAP && act_in[0]) |=> FUNC.forward_torque_cap)
    else $error("forward torque cap not routed");
  a_out_brake: assert property (@(posedge CLK) disable iff (RST)
    (code_out[0] == `DIOR_FO_BRAKE && !low_out[0]) |=> DO[0] == $past(STATUS.brake_control))
    else $error("output brake mismatch");
  a_out_zero_speed_flag: assert property (@(posedge CLK) disable iff (RST)
    (code_out[2] == `DIOR_FO_ZERO_SPEED_FLAG && !low_out[2]) |=> DO[2] == $past(STATUS.zero_speed_flag))
    else $error("output zero speed mismatch");
  a_low_polarity: assert property (@(posedge CLK) disable iff (RST)
    (low_in[0] && code_in[0] == `DIOR_FI_SERVO_EN && !di_s2[0]) |=> FUNC.servo_enable)
    else $error("active-low channel not inverted");
  a_reset_defaults: assert property (@(posedge CLK)
    $fell(RST) |-> (sel_in[0] == `DIOR_DEF_IN1 && sel_in[5] == `DIOR_DEF_IN6))
    else $error("selection defaults lost at reset");
  a_set_wins: assert property (@(posedge CLK) disable iff (RST)
    (ev[`DIOR_EV_EHALT] && wr_stat && WDATA[`DIOR_EV_EHALT]) |=> irq_stat[`DIOR_EV_EHALT])
    else $error("event lost to a clear in the same cycle");

  ////////////////////////////////////////////////////////////////////
  // Cover points
  c_write_sel:  cover property (@(posedge CLK) WR && ADDR == `DIOR_A_OUT_SEL0);
  c_halt:       cover property (@(posedge CLK) FUNC.emergency_halt);
  c_irq:        cover property (@(posedge CLK) IRQ);
  c_servo_on:   cover property (@(posedge CLK) FUNC.servo_enable && DO[1]);
  c_low_pol:    cover property (@(posedge CLK) low_in[0] && FUNC.servo_enable);
endmodule

// ### pkg/dior_cfg.svh
// Purpose: Constants for the discrete I/O function router
// Assumes: Selection values are decimal-coded, 0..199
// Notes:   Hundreds digit picks polarity, low two digits the function
`ifndef DIOR_CFG_SVH
`define DIOR_CFG_SVH
`define DIOR_NUM_IN        6
`define DIOR_NUM_OUT       3
`define DIOR_SEL_W         8
`define DIOR_HUNDRED       8'd100
// Input function codes
`define DIOR_FI_NONE       7'd0
`define DIOR_FI_SERVO_EN   7'd1
`define DIOR_FI_ALM_CLR    7'd2
`define DIOR_FI_GAIN       7'd3
`define DIOR_FI_PCLR       7'd4
`define DIOR_FI_ZHOLD      7'd5
`define DIOR_FI_CMDREV     7'd6
`define DIOR_FI_PBLOCK     7'd7
`define DIOR_FI_TLIM       7'd9
`define DIOR_FI_SLIM       7'd10
`define DIOR_FI_GEARN      7'd11
`define DIOR_FI_SPEED_CMD_SEL_BIT0       7'd14
`define DIOR_FI_SPEED_CMD_SEL_BIT1       7'd15
`define DIOR_FI_TRQ0       7'd16
`define DIOR_FI_TRQ1       7'd17
`define DIOR_FI_PS         7'd18
`define DIOR_FI_ST         7'd19
`define DIOR_FI_TP         7'd20
`define DIOR_FI_EHALT      7'd21
`define DIOR_FI_RINH       7'd22
`define DIOR_FI_FINH       7'd23
`define DIOR_FI_RTCAP      7'd25
`define DIOR_FI_FTCAP      7'd26
// Output function codes
`define DIOR_FO_READY      7'd1
`define DIOR_FO_ENABLED    7'd2
`define DIOR_FO_ZERO_SPEED_FLAG       7'd3
`define DIOR_FO_SPDR       7'd4
`define DIOR_FO_POSC       7'd5
`define DIOR_FO_TQL        7'd6
`define DIOR_FO_FAULT      7'd7
`define DIOR_FO_BRAKE      7'd8
`define DIOR_FO_OVLD       7'd9
`define DIOR_FO_WARN       7'd10
// Factory selections, active-high (hundreds digit 1)
`define DIOR_DEF_IN1       8'd101
`define DIOR_DEF_IN2       8'd102
`define DIOR_DEF_IN3       8'd104
`define DIOR_DEF_IN4       8'd122
`define DIOR_DEF_IN5       8'd123
`define DIOR_DEF_IN6       8'd121
`define DIOR_DEF_OUT1      8'd101
`define DIOR_DEF_OUT2      8'd102
`define DIOR_DEF_OUT3      8'd103
// Register offsets
`define DIOR_A_IN_SEL0     4'h0
`define DIOR_A_OUT_SEL0    4'h6
`define DIOR_A_STATUS      4'h9
`define DIOR_A_IRQ_STAT    4'ha
`define DIOR_A_IRQ_MASK    4'hb
`define DIOR_A_PINS        4'hc
// Status event bits
`define DIOR_EV_EHALT      0
`define DIOR_EV_RINH       1
`define DIOR_EV_FINH       2
`define DIOR_EV_W          3
`endif

// ### pkg/dior_pkg.sv
// Purpose: Types for the discrete I/O function router
// Assumes: dior_cfg.svh supplies the widths
// Notes:   Function bundles travel as packed structs
`include "dior_cfg.svh"
package dior_pkg;
  typedef struct packed {
    logic servo_enable;
    logic alarm_clear;
    logic gain_switch;
    logic pulse_count_clear;
    logic zero_speed_hold;
    logic command_reversal;
    logic pulse_block;
    logic torque_limit_enable;
    logic speed_limit_enable;
    logic gear_numerator_select;
    logic [1:0] speed_cmd_sel;
    logic [1:0] torque_cmd_sel;
    logic mode_pos_spd;
    logic mode_spd_trq;
    logic mode_trq_pos;
    logic emergency_halt;
    logic reverse_travel_inhibit;
    logic forward_travel_inhibit;
    logic reverse_torque_cap;
    logic forward_torque_cap;
  } dior_func_t;

  typedef struct packed {
    logic servo_ready;
    logic servo_enabled;
    logic zero_speed_flag;
    logic speed_reached;
    logic position_complete;
    logic torque_limit_reached;
    logic fault_output;
    logic brake_control;
    logic overload_caution;
    logic general_warning;
  } dior_stat_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dior_bus_t;
endpackage

// ### verification/dior_field.sv
// Purpose: Field-side model: switches on the input pins, status source for outputs
// Assumes: Bench states what the contacts and the drive status should be
// Notes:   Pins move just after a clock edge, as real contacts would
`timescale 1ns/1ps
module dior_field (
  input  wire logic                 clk,
  input  wire logic [5:0]           contact,
  input  wire dior_pkg::dior_stat_t stat_req,
  output logic [5:0]                di,
  output dior_pkg::dior_stat_t      status
);
  import dior_pkg::*;
  // Closed contact drives a level; one edge of wiring delay
  always @(posedge clk) begin
    di <= contact;
    status <= stat_req;
  end
endmodule

// ### verification/dior_router_test.sv
// Purpose: Self-checking bench for the discrete I/O function router
// Assumes: Register port answers one cycle after the read strobe
// Notes:   Pins reach FUNC four edges after a contact request
`timescale 1ns/1ps
`include "dior_cfg.svh"
module dior_router_test;
  import dior_pkg::*;
  logic       clk, rst, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [5:0] contact, di;
  logic [2:0] dout;
  logic       irq;
  dior_stat_t stat_req, status;
  dior_func_t func;
  int         fail_count, tests_run, cycles;
  // Bit order of FUNC, MSB first, as function codes
  int         tbl[22] = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 15, 14, 17, 16, 18, 19, 20,
                          21, 22, 23, 25, 26};
  dior_field dior_field_inst (.clk(clk), .contact(contact), .stat_req(stat_req),
                              .di(di), .status(status));
  dior_router dior_router_inst (.CLK(clk), .RST(rst), .DI(di), .STATUS(status),
                                .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
                                .RDATA(rdata), .DO(dout), .FUNC(func), .IRQ(irq));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {16'h0000, exp}, {16'h0000, rdata});
  endtask
  task automatic pins(input logic [5:0] c);
    @(posedge clk);
    contact <= c;
    repeat (4) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Factory selections and an unmapped place
  task automatic t_defaults();
    logic [7:0] dflt[9];
    dflt = '{8'h65, 8'h66, 8'h68, 8'h7a, 8'h7b, 8'h79, 8'h65, 8'h66, 8'h67};
    for (int i = 0; i < 9; i++)
      rd_chk(i[3:0], dflt[i]);
    rd_chk(4'hd, 8'h00);
  endtask
  // Open contact-b inputs latch events; mask gates the interrupt
  task automatic t_irq();
    rd_chk(4'ha, 8'h07);
    chk("irq", 24'h0, {23'h0, irq});
    pins(6'b111000);
    wr_reg(4'ha, 8'h07);
    rd_chk(4'ha, 8'h00);
    wr_reg(4'hb, 8'h01);
    rd_chk(4'hb, 8'h01);
    pins(6'b011000);
    // Interrupt follows the status bit by one edge
    @(posedge clk);
    #1;
    chk("irq", 24'h1, {23'h0, irq});
    chk("func", 24'h10, {2'b00, func});
    rd_chk(4'hc, 8'h18);
    wr_reg(4'ha, 8'h01);
    rd_chk(4'ha, 8'h01);
    pins(6'b110000);
    wr_reg(4'ha, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 24'h0, {23'h0, irq});
    rd_chk(4'ha, 8'h02);
    pins(6'b111000);
    wr_reg(4'ha, 8'h07);
  endtask
  // Every input code on channel 1, both contact levels
  task automatic t_inputs();
    logic [21:0] hit;
    logic        nc;
    for (int i = 0; i < 22; i++) begin
      hit = 22'h1 << (21 - i);
      nc = (tbl[i] >= 21 && tbl[i] <= 23);
      wr_reg(4'h0, 8'(100 + tbl[i]));
      pins(6'b111001);
      chk("func_on", {2'b00, nc ? 22'h0 : hit}, {2'b00, func});
      pins(6'b111000);
      chk("func_off", {2'b00, nc ? hit : 22'h0}, {2'b00, func});
    end
    wr_reg(4'h0, 8'h00);
    // Open contact is the active level for this low-polarity value
    pins(6'b111000);
    chk("func_zero", 24'h0, {2'b00, func});
    wr_reg(4'h0, 8'h01);
    pins(6'b111000);
    chk("func_low", 24'h200000, {2'b00, func});
    pins(6'b111001);
    chk("func_low_off", 24'h0, {2'b00, func});
    wr_reg(4'h0, 8'h65);
  endtask
  // Every output code on channel 1, others left at defaults
  task automatic t_outputs();
    for (int c = 1; c <= 10; c++) begin
      wr_reg(4'h6, 8'(100 + c));
      @(posedge clk);
      stat_req <= dior_stat_t'(10'h1 << (10 - c));
      repeat (3) @(posedge clk);
      #1;
      chk("do", {21'h0, c == 3, c == 2, 1'b1}, {21'h0, dout});
    end
    wr_reg(4'h6, 8'h00);
    @(posedge clk);
    stat_req <= dior_stat_t'(10'h3ff);
    repeat (3) @(posedge clk);
    #1;
    chk("do_zero", 24'h6, {21'h0, dout});
    rd_chk(4'h9, 8'h06);
    wr_reg(4'h6, 8'h01);
    @(posedge clk);
    stat_req <= '0;
    repeat (3) @(posedge clk);
    #1;
    chk("do_low", 24'h1, {21'h0, dout});
    // Channel 2 carries the fault, active low
    wr_reg(4'h7, 8'h07);
    repeat (2) @(posedge clk);
    #1;
    chk("do_fault", 24'h3, {21'h0, dout});
    @(posedge clk);
    stat_req <= dior_stat_t'(10'h008);
    repeat (3) @(posedge clk);
    #1;
    chk("do_fault_on", 24'h1, {21'h0, dout});
    rd_chk(4'h7, 8'h07);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    contact = 6'h00;
    stat_req = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_defaults();
    t_irq();
    t_inputs();
    t_outputs();
    print_verdict();
  end
endmodule
